// ### sdm_core.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Subtract key: accumulator becomes accumulator minus entry
// - Subtract by adding nines complement plus one
// - Negative difference kept complemented, no sign
// - Later overflowing addition raises overflow flag
// - Entry slots fed inverted to digit counter
// - Top digit carry in subtract: no overflow
// - Carry flag preset at subtract start
// - Subtract otherwise behaves exactly like add
// - Complement by inverting all nine slots
// - Digit is nine slots, thermometer coded
// - Shift multiplicand left by top multiplier order
// - Add multiplicand digit-value times per digit
// - Shift multiplicand right after each digit above the lowest
// - Continue down to lowest multiplier digit
// - Clear-then-multiply clears accumulator first
// - Multiply-accumulate keeps accumulator, adds product
// - Multiply-deduct subtracts each partial product
// - Digit counter modulo ten, carry to next
// - Each pass walks 24 digits, lowest first
module sdm_core
  import sdm_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [sdm_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  output logic                           busy_o,
  output logic                           overflow_o
);
  import sdm_pkg::*;

  // ---------------------------------------------------------------
  // Digit helpers
  // ---------------------------------------------------------------
  function automatic logic [SLOTS-1:0] to_slots(input logic [3:0] d);
    to_slots = 9'h1ff >> (DIGIT_MAX - d);
  endfunction

  function automatic logic [4:0] count_slots(input logic [SLOTS-1:0] s);
    logic [4:0] n;
    n = 5'd0;
    for (int i = 0; i < SLOTS; i++)
    begin
      n = n + {4'd0, s[i]};
    end
    count_slots = n;
  endfunction

  function automatic logic [4:0] digit_sum(input logic [SLOTS-1:0] a,
                                           input logic [SLOTS-1:0] e,
                                           input logic             cin);
    logic [4:0] n;
    n = count_slots(a) + count_slots(e) + {4'd0, cin};
    if (n > {1'b0, DIGIT_MAX})
    begin
      digit_sum = {1'b1, 4'(n - DIGIT_RADIX)};
    end
    else
    begin
      digit_sum = {1'b0, n[3:0]};
    end
  endfunction

  function automatic logic [3:0] digit_at(input logic [WORD_W-1:0] w,
                                          input logic [4:0]        i);
    digit_at = w[i*DIGIT_W +: DIGIT_W];
  endfunction

  function automatic logic [4:0] top_nonzero(input logic [WORD_W-1:0] w);
    logic [4:0] t;
    t = LOW_DIGIT;
    for (int i = 0; i < NUM_DIGITS; i++)
    begin
      if (w[i*DIGIT_W +: DIGIT_W] != 4'h0)
      begin
        t = 5'(i);
      end
    end
    top_nonzero = t;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sdm_state_t        state_reg;
  logic [WORD_W-1:0] acc_reg;
  logic [WORD_W-1:0] entry_reg;
  logic [WORD_W-1:0] mq_reg;
  logic [4:0]        dig_reg;
  logic [4:0]        c_reg;
  logic [4:0]        shl_reg;
  logic [3:0]        m_reg;
  logic              carry_flag;
  logic              pass_sub_reg;
  logic              multiply_accumulate_key_reg;
  logic              ovf_reg;
  logic              anysw_reg;
  logic [31:0]       prdata_reg;

  logic              setup;
  logic              wr_acc;
  logic              key_wr;
  logic              start_add;
  logic              start_sub;
  logic              start_mul;
  logic              top_digit_time;
  logic              lowest_digit_time;
  logic [SLOTS-1:0]  acc_slots;
  logic [SLOTS-1:0]  adder_input_gates;
  logic [4:0]        sum;
  logic [3:0]        mq_digit;
  logic [4:0]        mq_top;
  logic              more_adds;

  assign setup  = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign key_wr = wr_acc && (paddr_i == ADDR_KEYS) && (state_reg == ST_IDLE);

  assign start_add = key_wr && pwdata_i[KEY_ADD] && anysw_reg;
  assign start_sub = key_wr && pwdata_i[KEY_SUB] && anysw_reg
                     && !pwdata_i[KEY_ADD];
  assign start_mul = key_wr && !pwdata_i[KEY_ADD] && !pwdata_i[KEY_SUB]
                     && (pwdata_i[KEY_CLRMUL] || pwdata_i[KEY_MULACC]
                         || pwdata_i[KEY_MULDED]);

  assign top_digit_time    = (dig_reg == TOP_DIGIT);
  assign lowest_digit_time = (dig_reg == LOW_DIGIT);

  // ---------------------------------------------------------------
  // Serial digit adder
  // ---------------------------------------------------------------
  assign acc_slots = to_slots(digit_at(acc_reg, dig_reg));
  always_comb
  begin
    adder_input_gates = to_slots(digit_at(entry_reg, dig_reg));
    if (pass_sub_reg)
    begin
      adder_input_gates = ~adder_input_gates;
    end
  end
  assign sum       = digit_sum(acc_slots, adder_input_gates,
                               carry_flag);
  assign mq_digit  = digit_at(mq_reg, c_reg);
  assign mq_top    = top_nonzero(mq_reg);
  assign more_adds = (m_reg != 4'h1);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg    <= ST_IDLE;
      dig_reg      <= LOW_DIGIT;
      c_reg        <= LOW_DIGIT;
      shl_reg      <= LOW_DIGIT;
      m_reg        <= 4'h0;
      carry_flag   <= 1'b0;
      pass_sub_reg <= 1'b0;
      multiply_accumulate_key_reg     <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          dig_reg <= LOW_DIGIT;
          if (start_add || start_sub)
          begin
            carry_flag   <= start_sub;
            pass_sub_reg <= start_sub;
            multiply_accumulate_key_reg     <= 1'b0;
            state_reg    <= ST_PASS;
          end
          else if (start_mul)
          begin
            pass_sub_reg <= pwdata_i[KEY_MULDED];
            multiply_accumulate_key_reg     <= 1'b1;
            c_reg        <= mq_top;
            shl_reg      <= mq_top;
            state_reg    <= (mq_top != LOW_DIGIT) ? ST_SHL : ST_LOAD;
          end
        end
        ST_SHL:
        begin
          shl_reg <= shl_reg - 5'd1;
          if (shl_reg == 5'd1)
          begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          m_reg      <= mq_digit;
          carry_flag <= pass_sub_reg;
          dig_reg    <= LOW_DIGIT;
          if (mq_digit != 4'h0)
          begin
            state_reg <= ST_PASS;
          end
          else if (c_reg == LOW_DIGIT)
          begin
            state_reg <= ST_FIN;
          end
          else
          begin
            state_reg <= ST_SHR;
          end
        end
        ST_PASS:
        begin
          carry_flag <= sum[4];
          dig_reg    <= dig_reg + 5'd1;
          if (top_digit_time)
          begin
            dig_reg    <= LOW_DIGIT;
            carry_flag <= pass_sub_reg;
            if (!multiply_accumulate_key_reg)
            begin
              state_reg <= ST_FIN;
            end
            else
            begin
              m_reg <= m_reg - 4'h1;
              if (!more_adds)
              begin
                state_reg <= (c_reg == LOW_DIGIT) ? ST_FIN : ST_SHR;
              end
            end
          end
        end
        ST_SHR:
        begin
          c_reg     <= c_reg - 5'd1;
          state_reg <= ST_LOAD;
        end
        ST_FIN:
        begin
          carry_flag <= 1'b0;
          state_reg  <= ST_IDLE;
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acc_reg <= '0;
    end
    else if (start_mul && pwdata_i[KEY_CLRMUL])
    begin
      acc_reg <= '0;
    end
    else if (state_reg == ST_PASS)
    begin
      acc_reg[dig_reg*DIGIT_W +: DIGIT_W] <= sum[3:0];
    end
    else if (state_reg == ST_IDLE && wr_acc)
    begin
      if (paddr_i == ADDR_ACC0)
      begin
        acc_reg[31:0] <= pwdata_i;
      end
      else if (paddr_i == ADDR_ACC1)
      begin
        acc_reg[63:32] <= pwdata_i;
      end
      else if (paddr_i == ADDR_ACC2)
      begin
        acc_reg[95:64] <= pwdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Entry (multiplicand) and multiplier registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      entry_reg <= '0;
    end
    else if (state_reg == ST_SHL)
    begin
      entry_reg <= entry_reg << DIGIT_W;
    end
    else if (state_reg == ST_SHR)
    begin
      entry_reg <= entry_reg >> DIGIT_W;
    end
    else if (state_reg == ST_FIN)
    begin
      entry_reg <= '0;
    end
    else if (state_reg == ST_IDLE && wr_acc)
    begin
      if (paddr_i == ADDR_ENT0)
      begin
        entry_reg[31:0] <= pwdata_i;
      end
      else if (paddr_i == ADDR_ENT1)
      begin
        entry_reg[63:32] <= pwdata_i;
      end
      else if (paddr_i == ADDR_ENT2)
      begin
        entry_reg[95:64] <= pwdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mq_reg <= '0;
    end
    else if (state_reg == ST_IDLE && wr_acc)
    begin
      if (paddr_i == ADDR_MQ0)
      begin
        mq_reg[31:0] <= pwdata_i;
      end
      else if (paddr_i == ADDR_MQ1)
      begin
        mq_reg[63:32] <= pwdata_i;
      end
      else if (paddr_i == ADDR_MQ2)
      begin
        mq_reg[95:64] <= pwdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Overflow flag and any-register switch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ovf_reg <= 1'b0;
    end
    else if (state_reg == ST_PASS && top_digit_time && sum[4]
             && !pass_sub_reg)
    begin
      ovf_reg <= 1'b1;
    end
    else if (wr_acc && paddr_i == ADDR_STAT && pwdata_i[STAT_OVF])
    begin
      ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      anysw_reg <= ANYSW_RST;
    end
    else if (wr_acc && paddr_i == ADDR_KEYS)
    begin
      anysw_reg <= pwdata_i[KEY_ANYSW];
    end
  end

  // ---------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prdata_reg <= 32'h0;
    end
    else if (setup)
    begin
      if (paddr_i == ADDR_ACC0)       prdata_reg <= acc_reg[31:0];
      else if (paddr_i == ADDR_ACC1)  prdata_reg <= acc_reg[63:32];
      else if (paddr_i == ADDR_ACC2)  prdata_reg <= acc_reg[95:64];
      else if (paddr_i == ADDR_ENT0)  prdata_reg <= entry_reg[31:0];
      else if (paddr_i == ADDR_ENT1)  prdata_reg <= entry_reg[63:32];
      else if (paddr_i == ADDR_ENT2)  prdata_reg <= entry_reg[95:64];
      else if (paddr_i == ADDR_MQ0)   prdata_reg <= mq_reg[31:0];
      else if (paddr_i == ADDR_MQ1)   prdata_reg <= mq_reg[63:32];
      else if (paddr_i == ADDR_MQ2)   prdata_reg <= mq_reg[95:64];
      else if (paddr_i == ADDR_KEYS)
        prdata_reg <= {23'h0, anysw_reg, 8'h0};
      else if (paddr_i == ADDR_STAT)
        prdata_reg <= {30'h0, ovf_reg, (state_reg != ST_IDLE)};
      else                            prdata_reg <= 32'h0;
    end
  end

  assign prdata_o   = prdata_reg;
  assign pready_o   = 1'b1;
  assign pslverr_o  = psel_i && penable_i && (paddr_i > ADDR_STAT
                      || paddr_i[1:0] != 2'b00);
  assign busy_o     = (state_reg != ST_IDLE);
  assign overflow_o = ovf_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_sub_preset;
    @(posedge clk_i) disable iff (!nrst_i)
    start_sub |=> (state_reg == ST_PASS) && carry_flag && pass_sub_reg;
  endproperty
  a_sub_preset: assert property (p_sub_preset)
    else $error("carry not preset at subtract start");

  property p_no_ovf_sub;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ST_PASS && pass_sub_reg && !ovf_reg) |=> !ovf_reg;
  endproperty
  a_no_ovf_sub: assert property (p_no_ovf_sub)
    else $error("overflow raised during subtract");

  property p_ovf_add;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ST_PASS && top_digit_time && sum[4] && !pass_sub_reg)
      |=> ovf_reg;
  endproperty
  a_ovf_add: assert property (p_ovf_add)
    else $error("overflow missed on add carry");

  property p_complement;
    @(posedge clk_i) disable iff (!nrst_i)
    pass_sub_reg |-> (count_slots(adder_input_gates)
      == 5'(DIGIT_MAX) - {1'b0, digit_at(entry_reg, dig_reg)});
  endproperty
  a_complement: assert property (p_complement)
    else $error("entry digit not nines complemented");

  property p_digit_walk;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ST_PASS && lowest_digit_time) |=> 
      (state_reg == ST_PASS && dig_reg == 5'd1) ##22
      (state_reg == ST_PASS && top_digit_time);
  endproperty
  a_digit_walk: assert property (p_digit_walk)
    else $error("pass did not walk all digits");

  property p_clear_then_multiply_key;
    @(posedge clk_i) disable iff (!nrst_i)
    (start_mul && pwdata_i[KEY_CLRMUL]) |=> (acc_reg == '0);
  endproperty
  a_clear_then_multiply_key: assert property (p_clear_then_multiply_key)
    else $error("accumulator not cleared before product");

  property p_shr;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ST_SHR) |=>
      (entry_reg == ($past(entry_reg) >> DIGIT_W)) && (state_reg == ST_LOAD);
  endproperty
  a_shr: assert property (p_shr)
    else $error("multiplicand not shifted right");

  property p_shl;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ST_SHL) |=> (entry_reg == ($past(entry_reg) << DIGIT_W));
  endproperty
  a_shl: assert property (p_shl)
    else $error("multiplicand not shifted left");

  property p_load;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ST_LOAD && mq_digit != 4'h0) |=>
      (m_reg == $past(mq_digit)) && (state_reg == ST_PASS);
  endproperty
  a_load: assert property (p_load)
    else $error("multiplier digit not loaded");

  property p_lowest;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ST_SHR) |-> (c_reg != LOW_DIGIT);
  endproperty
  a_lowest: assert property (p_lowest)
    else $error("shift below lowest multiplier digit");

  property p_acc_digit;
    @(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ST_PASS) |=>
      digit_at(acc_reg, $past(dig_reg)) == $past(sum[3:0]);
  endproperty
  a_acc_digit: assert property (p_acc_digit)
    else $error("accumulator digit not written");

  c_sub: cover property (@(posedge clk_i) disable iff (!nrst_i)
    start_sub ##25 (state_reg == ST_FIN));
  c_mul_shift: cover property (@(posedge clk_i) disable iff (!nrst_i)
    (state_reg == ST_SHR) ##1 (state_reg == ST_LOAD));
  c_ovf: cover property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(ovf_reg));

endmodule
`default_nettype wire

// ### sdm_pkg.sv
`default_nettype none
package sdm_pkg;

  // ---------------------------------------------------------------
  // Word format
  // ---------------------------------------------------------------
  localparam int unsigned NUM_DIGITS  = 24;
  localparam int unsigned DIGIT_W     = 4;
  localparam int unsigned WORD_W      = NUM_DIGITS * DIGIT_W;
  localparam int unsigned SLOTS       = 9;
  localparam logic [4:0]  TOP_DIGIT   = 5'd23;
  localparam logic [4:0]  LOW_DIGIT   = 5'd0;
  localparam logic [3:0]  DIGIT_MAX   = 4'h9;
  localparam logic [4:0]  DIGIT_RADIX = 5'h0a;

  // ---------------------------------------------------------------
  // APB map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned APB_AW      = 8;
  localparam logic [7:0]  ADDR_ACC0   = 8'h00;
  localparam logic [7:0]  ADDR_ACC1   = 8'h04;
  localparam logic [7:0]  ADDR_ACC2   = 8'h08;
  localparam logic [7:0]  ADDR_ENT0   = 8'h0c;
  localparam logic [7:0]  ADDR_ENT1   = 8'h10;
  localparam logic [7:0]  ADDR_ENT2   = 8'h14;
  localparam logic [7:0]  ADDR_MQ0    = 8'h18;
  localparam logic [7:0]  ADDR_MQ1    = 8'h1c;
  localparam logic [7:0]  ADDR_MQ2    = 8'h20;
  localparam logic [7:0]  ADDR_KEYS   = 8'h24;
  localparam logic [7:0]  ADDR_STAT   = 8'h28;

  // Key register bits (write one to press)
  localparam int unsigned KEY_ADD     = 0;
  localparam int unsigned KEY_SUB     = 1;
  localparam int unsigned KEY_CLRMUL  = 2;
  localparam int unsigned KEY_MULACC  = 3;
  localparam int unsigned KEY_MULDED  = 4;
  localparam int unsigned KEY_ANYSW   = 8;

  // Status register bits
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_OVF    = 1;

  localparam logic        ANYSW_RST   = 1'b1;

  typedef enum {
    ST_IDLE,
    ST_SHL,
    ST_LOAD,
    ST_PASS,
    ST_SHR,
    ST_FIN
  } sdm_state_t;

endpackage
`default_nettype wire

// ### sdm_operator.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Operator side: bus master for keys and storage registers
// ---------------------------------------------------------------
module sdm_operator
  import sdm_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       pready_i,
  input  wire logic [31:0]                prdata_i,
  input  wire logic                       pslverr_i,
  output logic                            psel_o,
  output logic                            penable_o,
  output logic                            pwrite_o,
  output logic      [sdm_pkg::APB_AW-1:0] paddr_o,
  output logic      [31:0]                pwdata_o
);
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
  end

  // Entered right after a rising edge; one idle edge before return
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### sdm_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module sdm_core_tb;
  import sdm_pkg::*;
  logic        clk_i;
  logic        nrst_i;
  logic        psel, penable, pwrite, pready, pslverr, busy, ovf;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [95:0] x_acc;
  logic        x_ovf;
  int          bad_count, n_tests, cyc, run, busy_len, x_len;

  sdm_core i_sdm_core (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .busy_o(busy), .overflow_o(ovf));

  sdm_operator i_sdm_operator (
    .clk_i(clk_i), .pready_i(pready), .prdata_i(prdata),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Length of each busy run, and hang guard
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (busy === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      busy_len <= run;
      run <= 0;
    end
    if (cyc == 60000)
    begin
      bad_count++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Bus helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    i_sdm_operator.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    output logic e);
    i_sdm_operator.xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wr3(input logic [7:0] a, input logic [95:0] w);
    for (int i = 0; i < 3; i++)
      wr(a + 8'(4 * i), w[32*i+:32]);
  endtask

  task automatic rd3(input logic [7:0] a, output logic [95:0] w);
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 3; i++)
    begin
      rd(a + 8'(4 * i), q, e);
      w[32*i+:32] = q;
    end
  endtask

  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [95:0] rnd(int nd);
    logic [95:0] w;
    w = '0;
    for (int i = 0; i < nd; i++)
    begin
      seed = lfsr(seed);
      w[4*i+:4] = 4'(seed % 10);
    end
    return w;
  endfunction

  // One pass: digit-serial sum, optional nines complement plus one
  function automatic logic [96:0] addw(logic [95:0] a, logic [95:0] b,
                                       bit neg);
    int          s;
    int          c;
    logic [96:0] r;
    c = neg;
    for (int i = 0; i < 24; i++)
    begin
      s = a[4*i+:4] + (neg ? 9 - b[4*i+:4] : b[4*i+:4]) + c;
      c = (s > 9);
      r[4*i+:4] = 4'(s % 10);
    end
    r[96] = c[0];
    return r;
  endfunction

  task automatic model(input int k, input logic [95:0] e,
                       input logic [95:0] m);
    logic [96:0] r;
    int          top;
    top = 0;
    x_len = 25;
    if (k < KEY_CLRMUL)
    begin
      r = addw(x_acc, e, k == KEY_SUB);
      x_acc = r[95:0];
      x_ovf = r[96] && k == KEY_ADD;
      return;
    end
    x_ovf = 1'b0;
    for (int i = 0; i < 24; i++)
      if (m[4*i+:4] != 0) top = i;
    if (k == KEY_CLRMUL) x_acc = '0;
    e = e << (4 * top);
    x_len = top + 1;
    for (int c = top; c >= 0; c--)
    begin
      x_len += 1 + 24 * m[4*c+:4] + (c > 0);
      repeat (m[4*c+:4])
      begin
        r = addw(x_acc, e, k == KEY_MULDED);
        x_acc = r[95:0];
        x_ovf |= r[96] && k != KEY_MULDED;
      end
      e = e >> 4;
    end
  endtask

  task automatic op(input int k, input logic [95:0] a,
                    input logic [95:0] e, input logic [95:0] m);
    logic [95:0] q;
    logic [31:0] s;
    logic        er;
    wr(ADDR_STAT, 32'h2);
    wr3(ADDR_ACC0, a);
    wr3(ADDR_ENT0, e);
    wr3(ADDR_MQ0, m);
    x_acc = a;
    model(k, e, m);
    wr(ADDR_KEYS, 32'h100 | (32'h1 << k));
    do
    begin
      @(negedge clk_i);
    end
    while (busy !== 1'b0);
    @(posedge clk_i);
    rd3(ADDR_ACC0, q);
    `CHK(q, x_acc)
    rd3(ADDR_ENT0, q);
    `CHK(q, 96'h0)
    rd(ADDR_STAT, s, er);
    `CHK(s[1:0], {x_ovf, 1'b0})
    `CHK(ovf, x_ovf)
    `CHK(busy_len, x_len)
    $display("test key %0d done", k);
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] q;
    logic        e;
    nrst_i = 1'b0;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    run = 0;
    busy_len = 0;
    seed = 32'h1691ced7;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(ADDR_STAT, q, e);
    `CHK(q, 32'h0)
    rd(8'h2c, q, e);
    `CHK({e, q}, 33'h1_0000_0000)
    // Switch off: subtract key must not start
    wr(ADDR_KEYS, 32'h0);
    wr(ADDR_KEYS, 32'h2);
    `CHK(busy, 1'b0)
    rd(ADDR_KEYS, q, e);
    `CHK(q, 32'h0)
    wr(ADDR_KEYS, 32'h100);
    rd(ADDR_KEYS, q, e);
    `CHK(q, 32'h100)
    $display("test switch done");
    op(KEY_SUB, 96'h85, 96'h70, 96'h0);
    op(KEY_SUB, 96'h70, 96'h88, 96'h0);
    op(KEY_SUB, 96'h0, 96'h0, 96'h0);
    op(KEY_SUB, 96'h0, 96'h5, 96'h0);
    op(KEY_ADD, x_acc, 96'h10, 96'h0);
    for (int i = 0; i < 6; i++)
      op(KEY_SUB, rnd(24), rnd(24), 96'h0);
    op(KEY_CLRMUL, rnd(24), 96'h351, 96'h422);
    op(KEY_MULACC, 96'h1000, 96'h351, 96'h422);
    op(KEY_MULDED, 96'h1000, 96'h351, 96'h422);
    op(KEY_MULACC, rnd(24), rnd(12), 96'h0);
    for (int i = 0; i < 3; i++)
      op(KEY_CLRMUL + i, rnd(24), rnd(12), rnd(12));
    finish_test();
  end
endmodule
`default_nettype wire
